// file: wire_cfg_pkg.sv
// Shared constants for the one-wire configuration link and its two ends.
// Assumes both ends run from one 10 MHz pclk with an active-low async reset.
package wire_cfg_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_HZ = 10_000_000;

  // Symbol widths in link clock cycles, in pilot widths and in half pilot widths.
  localparam int PILOT_MIN = 8;
  localparam int PILOT_TYP = 10;
  localparam int PILOT_MAX = 20;
  localparam int ZERO_MAX_HALF = 3;
  localparam int ONE_MIN_HALF = 4;
  localparam int ONE_MAX_HALF = 7;
  localparam int ONE_TYP_TP = 3;
  localparam int GAP_MIN_HALF = 2;
  localparam int GAP_MAX_HALF = 4;
  localparam int STOP_HIGH_CLKS = 128;
  localparam int STOP_LOW_TP = 8;

  // Frame layout.
  localparam int PAYLOAD_BITS = 24;
  localparam logic [6:0] DEV_ADDR = 7'h53;
  localparam logic WRITE_FLAG = 1'b0;
  localparam logic [7:0] DEV_WRITE_BYTE = {DEV_ADDR, WRITE_FLAG};

  // Unlock sequence and detection registers.
  localparam int UNLOCK_STEPS = 5;
  localparam logic [7:0] UNLOCK_DATA = 8'h00;
  localparam logic [7:0] UNLOCK_ADDR [UNLOCK_STEPS] = '{8'h5C, 8'h3E, 8'h6F, 8'h3B, 8'h4C};
  localparam logic [7:0] REG_DETECT_ENABLE = 8'h29;
  localparam logic [7:0] REG_LOWPASS = 8'h35;
  localparam logic [7:0] REG_THRESHOLD = 8'h36;
  localparam int ENABLE_BIT = 3;
  localparam int LOWPASS_W = 3;
  localparam int THRESHOLD_W = 4;

  // The link clock counts as stopped after this long without an edge.
  localparam int CLK_STOP_NS = 40_000;
  localparam int CLK_STOP_CYCLES = CLK_STOP_NS / CLK_PERIOD_NS;

  // Link clock half period in pclk cycles, kept between 50 kHz and 200 kHz.
  localparam int LINK_HZ_MIN = 50_000;
  localparam int LINK_HZ_MAX = 200_000;
  localparam int DIV_MIN = CLK_HZ / (2 * LINK_HZ_MAX);
  localparam int DIV_MAX = CLK_HZ / (2 * LINK_HZ_MIN);
  localparam logic [7:0] DIV_RESET = 8'h32;

  // Controller register map (APB, byte addresses).
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PILOT = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_STOPLOW_BIT = 1;
  localparam int CTRL_DIV_LSB = 8;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_WAKE_BIT = 1;
endpackage

// file: one_wire_if.sv
// Pins between the host controller and the microphone configuration end.
// Assumes the bench ties both modports together; all pins are one-way.
interface one_wire_if;
  logic pdm_clk;
  logic config_wire_pin;
  logic wake;
  modport host (output pdm_clk, output config_wire_pin, input wake);
  modport mic (input pdm_clk, input config_wire_pin, output wake);
endinterface

// file: mic_config_rx.sv
// Microphone end: one-wire write receiver, unlock tracker, analog detect settings.
// Assumes pdm_clk and the pin arrive asynchronously and are sampled on pclk.
// Operation
// - Host keeps link clock above 50 kHz
// - Pilot 8 to 20 cycles sets width
// - Zero is up to 1.5 pilot widths
// - One is 2 to 3.5 pilot widths
// - High over 128 cycles ends write
// - Low over 8 pilot widths ends write
// - Low gaps of 1 to 2 widths
// - Host uses typical symbol widths
// - Frame is pilot, 24 bits, stop
// - First byte is device address, write
// - Address, register, data, MSB first
// - Five unlock writes open configuration
// - Unlock holds until power is lost
// - Wake follows threshold and cutoff conditions
// - Low-pass code in 0x35 bits 2:0
// - Threshold code in 0x36 bits 3:0
// - Enable in 0x29 bit 3, reset off
// - Detect only with enable and clock stopped
// - Sleep writes need 50 to 200 kHz
// - Enable stays until cleared or power loss
//
// Register access over APB was decided locally.
module mic_config_rx
  import wire_cfg_pkg::*;
(
  // Clock and power-up reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link pins.
  one_wire_if.mic link,
  // Analog comparator results.
  input wire logic sound_above_threshold,
  input wire logic sound_below_cutoff,
  // Settings and status.
  output logic analog_detect_enable,
  output logic [LOWPASS_W-1:0] analog_lowpass_code,
  output logic [THRESHOLD_W-1:0] analog_threshold_code,
  output logic config_unlocked,
  output logic link_clock_stopped,
  output logic write_accepted,
  output logic frame_dropped
);
  typedef enum logic [2:0] {RX_IDLE, RX_HIGH, RX_LOW, RX_HOLD} rx_state_type;

  localparam int CNT_W = 12;
  localparam int STOP_W = 12;

  logic [1:0] clk_sync_q;
  logic [1:0] pin_sync_q;
  logic [1:0] above_sync_q;
  logic [1:0] below_sync_q;
  logic clk_prev_q;
  logic [STOP_W-1:0] idle_cnt_q;
  rx_state_type state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] tp_q;
  logic pilot_q;
  logic err_q;
  logic [4:0] bits_q;
  logic [PAYLOAD_BITS-1:0] shift_q;
  logic [2:0] unlock_step_q;
  logic enable_q;
  logic [LOWPASS_W-1:0] lowpass_q;
  logic [THRESHOLD_W-1:0] threshold_q;
  logic wake_q;
  logic accepted_q;
  logic dropped_q;

  wire line = pin_sync_q[1];
  wire link_edge = clk_sync_q[1] & ~clk_prev_q;
  wire stopped = (idle_cnt_q == STOP_W'(CLK_STOP_CYCLES));
  wire [CNT_W-1:0] cnt_inc = (cnt_q == {CNT_W{1'b1}}) ? cnt_q : cnt_q + 1'b1;

  // Zero, one and gap width checks in half pilot widths to avoid fractions.
  wire [CNT_W:0] width2 = {cnt_q, 1'b0};
  wire [CNT_W+3:0] tp_half = {4'h0, tp_q};
  wire pilot_ok = (cnt_q >= CNT_W'(PILOT_MIN)) && (cnt_q <= CNT_W'(PILOT_MAX));
  wire is_zero = width2 <= (CNT_W+1)'(tp_half * ZERO_MAX_HALF);
  wire is_one = (width2 >= (CNT_W+1)'(tp_half * ONE_MIN_HALF)) &&
                (width2 <= (CNT_W+1)'(tp_half * ONE_MAX_HALF));
  wire gap_ok = (width2 >= (CNT_W+1)'(tp_half * GAP_MIN_HALF)) &&
                (width2 <= (CNT_W+1)'(tp_half * GAP_MAX_HALF));
  wire stop_high = cnt_q >= CNT_W'(STOP_HIGH_CLKS);
  wire stop_low = {4'h0, cnt_q} >= (CNT_W+4)'(tp_half * STOP_LOW_TP);

  // A frame is good only with a valid pilot, exactly 24 clean bits and our address.
  wire frame_good = !err_q && !pilot_q && (bits_q == 5'(PAYLOAD_BITS)) &&
                    (shift_q[23:16] == DEV_WRITE_BYTE);
  wire [7:0] reg_addr = shift_q[15:8];
  wire [7:0] reg_data = shift_q[7:0];
  wire unlocked = (unlock_step_q == 3'(UNLOCK_STEPS));
  wire unlock_match = !unlocked && (reg_data == UNLOCK_DATA) &&
                      (reg_addr == UNLOCK_ADDR[unlock_step_q]);
  wire unlock_first = (reg_data == UNLOCK_DATA) && (reg_addr == UNLOCK_ADDR[0]);
  wire bit_fault = pilot_q ? !pilot_ok :
                   ((bits_q == 5'(PAYLOAD_BITS)) || (!is_zero && !is_one));

  // Frame end: stop seen in the current symbol.
  logic finish;
  always_comb begin
    finish = 1'b0;
    if (link_edge) begin
      if (state_q == RX_HIGH && line && stop_high) begin
        finish = 1'b1;
      end else if (state_q == RX_LOW && !line && stop_low) begin
        finish = 1'b1;
      end
    end
  end
  wire commit = finish && frame_good;
  wire abort = (state_q != RX_IDLE) && (state_q != RX_HOLD) && stopped && !link_edge;

  // Both link pins and the comparators are asynchronous to pclk.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync_q <= 2'b00;
      pin_sync_q <= 2'b00;
      above_sync_q <= 2'b00;
      below_sync_q <= 2'b00;
      clk_prev_q <= 1'b0;
    end else begin
      clk_sync_q <= {clk_sync_q[0], link.pdm_clk};
      pin_sync_q <= {pin_sync_q[0], link.config_wire_pin};
      above_sync_q <= {above_sync_q[0], sound_above_threshold};
      below_sync_q <= {below_sync_q[0], sound_below_cutoff};
      clk_prev_q <= clk_sync_q[1];
    end
  end

  // Time since the last link clock edge; saturates to mark the clock as stopped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= STOP_W'(CLK_STOP_CYCLES);
    end else if (link_edge) begin
      idle_cnt_q <= '0;
    end else if (!stopped) begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  // Symbol receiver, stepped once per rising link clock edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RX_IDLE;
      cnt_q <= '0;
      tp_q <= '0;
      pilot_q <= 1'b0;
      err_q <= 1'b0;
      bits_q <= '0;
      shift_q <= '0;
    end else if (abort) begin
      state_q <= RX_IDLE;
    end else if (link_edge) begin
      case (state_q)
        RX_IDLE: begin
          if (line) begin
            state_q <= RX_HIGH;
            cnt_q <= CNT_W'(1);
            pilot_q <= 1'b1;
            err_q <= 1'b0;
            bits_q <= '0;
          end
        end
        RX_HIGH: begin
          if (line) begin
            cnt_q <= cnt_inc;
            if (stop_high) begin
              state_q <= RX_HOLD;
            end
          end else begin
            state_q <= RX_LOW;
            cnt_q <= CNT_W'(1);
            pilot_q <= 1'b0;
            if (pilot_q) begin
              tp_q <= cnt_q;
            end else if (!bit_fault) begin
              shift_q <= {shift_q[PAYLOAD_BITS-2:0], is_one};
              bits_q <= bits_q + 1'b1;
            end
            if (bit_fault) begin
              err_q <= 1'b1;
            end
          end
        end
        RX_LOW: begin
          if (!line) begin
            cnt_q <= cnt_inc;
            if (stop_low) begin
              state_q <= RX_IDLE;
            end
          end else begin
            state_q <= RX_HIGH;
            cnt_q <= CNT_W'(1);
            if (!gap_ok) begin
              err_q <= 1'b1;
            end
          end
        end
        default: begin
          if (!line) begin
            state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Unlock tracker and detection settings; apart from accepted writes, only power-up reset clears them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_step_q <= '0;
      enable_q <= 1'b0;
      lowpass_q <= '0;
      threshold_q <= '0;
    end else if (commit) begin
      if (unlock_match) begin
        unlock_step_q <= unlock_step_q + 1'b1;
      end else if (!unlocked) begin
        unlock_step_q <= unlock_first ? 3'(1) : 3'(0);
      end
      if (unlocked) begin
        if (reg_addr == REG_DETECT_ENABLE) begin
          enable_q <= reg_data[ENABLE_BIT];
        end else if (reg_addr == REG_LOWPASS) begin
          lowpass_q <= reg_data[LOWPASS_W-1:0];
        end else if (reg_addr == REG_THRESHOLD) begin
          threshold_q <= reg_data[THRESHOLD_W-1:0];
        end
      end
    end
  end

  // Wake follows the comparators only while enabled and the clock is off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
      accepted_q <= 1'b0;
      dropped_q <= 1'b0;
    end else begin
      wake_q <= enable_q && stopped && above_sync_q[1] && below_sync_q[1];
      accepted_q <= commit;
      dropped_q <= (finish && !frame_good) || abort;
    end
  end

  assign link.wake = wake_q;
  assign analog_detect_enable = enable_q;
  assign analog_lowpass_code = lowpass_q;
  assign analog_threshold_code = threshold_q;
  assign config_unlocked = unlocked;
  assign link_clock_stopped = stopped;
  assign write_accepted = accepted_q;
  assign frame_dropped = dropped_q;
endmodule

// file: wire_cfg_host.sv
// Host end: APB-controlled link clock generator and one-wire write transmitter.
// Assumes an APB master on pclk and the microphone end on the link interface.
module wire_cfg_host
  import wire_cfg_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link pins.
  one_wire_if.host link
);
  typedef enum logic [2:0] {TX_IDLE, TX_PILOT, TX_GAP, TX_BIT, TX_STOPH, TX_TAIL} tx_state_type;

  logic run_q;
  logic stop_low_q;
  logic [7:0] div_q;
  logic [4:0] tp_q;
  logic [15:0] cmd_q;
  logic [7:0] div_cnt_q;
  logic pdm_q;
  tx_state_type state_q;
  logic [7:0] cnt_q;
  logic [4:0] bits_q;
  logic [PAYLOAD_BITS-1:0] shift_q;
  logic [1:0] wake_sync_q;

  wire access = psel && penable;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_pilot = (paddr == OFS_PILOT);
  wire hit_cmd = (paddr == OFS_CMD);
  wire hit_status = (paddr == OFS_STATUS);
  wire hit = hit_ctrl || hit_pilot || hit_cmd || hit_status;
  wire busy = (state_q != TX_IDLE);
  wire start = access && pwrite && hit_cmd && !busy;

  // Divider and pilot writes are clamped into their legal ranges.
  wire [7:0] div_wr = pwdata[CTRL_DIV_LSB +: 8];
  wire [7:0] div_new = (div_wr < 8'(DIV_MIN)) ? 8'(DIV_MIN) :
                       (div_wr > 8'(DIV_MAX)) ? 8'(DIV_MAX) : div_wr;
  wire [4:0] tp_wr = pwdata[4:0];
  wire [4:0] tp_new = (tp_wr < 5'(PILOT_MIN)) ? 5'(PILOT_MIN) :
                      (tp_wr > 5'(PILOT_MAX)) ? 5'(PILOT_MAX) : tp_wr;

  wire [31:0] ctrl_rd = {16'h0000, div_q, 6'h00, stop_low_q, run_q};
  wire [31:0] status_rd = {30'h0, wake_sync_q[1], busy};
  assign prdata = hit_ctrl ? ctrl_rd :
                  hit_pilot ? {27'h0, tp_q} :
                  hit_cmd ? {16'h0000, cmd_q} :
                  hit_status ? status_rd : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = access && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      stop_low_q <= 1'b0;
      div_q <= DIV_RESET;
      tp_q <= 5'(PILOT_TYP);
      cmd_q <= '0;
    end else if (access && pwrite) begin
      if (hit_ctrl) begin
        run_q <= pwdata[CTRL_RUN_BIT];
        stop_low_q <= pwdata[CTRL_STOPLOW_BIT];
        div_q <= div_new;
      end else if (hit_pilot) begin
        tp_q <= tp_new;
      end else if (start) begin
        cmd_q <= pwdata[15:0];
      end
    end
  end

  // Link clock runs on request and always for the whole of a write.
  wire clk_on = run_q || busy;
  wire div_wrap = (div_cnt_q >= div_q - 8'h01);
  wire fall = clk_on && div_wrap && pdm_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= '0;
      pdm_q <= 1'b0;
      wake_sync_q <= 2'b00;
    end else begin
      wake_sync_q <= {wake_sync_q[0], link.wake};
      if (!clk_on) begin
        div_cnt_q <= '0;
        pdm_q <= 1'b0;
      end else if (div_wrap) begin
        div_cnt_q <= '0;
        pdm_q <= !pdm_q;
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
      end
    end
  end

  // Typical widths: one pilot width for zeros and gaps, three for ones.
  wire [7:0] tp8 = {3'b000, tp_q};
  wire [7:0] bit_width = shift_q[PAYLOAD_BITS-1] ? 8'(tp8 * ONE_TYP_TP) : tp8;
  wire [7:0] stop_low_width = 8'(tp8 * STOP_LOW_TP + 1);
  wire [7:0] stop_high_width = 8'(STOP_HIGH_CLKS + 1);
  // A link clock that is already high at the start loses its rise, so count one more fall.
  wire [7:0] pilot_len = (pdm_q && !div_wrap) ? tp8 + 8'h01 : tp8;

  // Symbols change on the falling link edge so the receiver samples them mid-cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= TX_IDLE;
      cnt_q <= '0;
      bits_q <= '0;
      shift_q <= '0;
    end else if (start) begin
      state_q <= TX_PILOT;
      cnt_q <= pilot_len;
      bits_q <= 5'(PAYLOAD_BITS);
      shift_q <= {DEV_WRITE_BYTE, pwdata[15:0]};
    end else if (fall) begin
      if (cnt_q > 8'h01) begin
        cnt_q <= cnt_q - 8'h01;
      end else begin
        case (state_q)
          TX_PILOT: begin
            state_q <= TX_GAP;
            cnt_q <= tp8;
          end
          TX_GAP: begin
            if (bits_q == '0) begin
              state_q <= TX_STOPH;
              cnt_q <= stop_high_width;
            end else begin
              state_q <= TX_BIT;
              cnt_q <= bit_width;
            end
          end
          TX_BIT: begin
            bits_q <= bits_q - 5'h01;
            shift_q <= {shift_q[PAYLOAD_BITS-2:0], 1'b0};
            if (bits_q == 5'h01 && stop_low_q) begin
              state_q <= TX_TAIL;
              cnt_q <= stop_low_width;
            end else begin
              state_q <= TX_GAP;
              cnt_q <= tp8;
            end
          end
          TX_STOPH: begin
            state_q <= TX_TAIL;
            cnt_q <= tp8;
          end
          TX_TAIL: begin
            state_q <= TX_IDLE;
          end
          default: begin
            state_q <= TX_IDLE;
          end
        endcase
      end
    end
  end

  assign link.pdm_clk = pdm_q;
  assign link.config_wire_pin = (state_q == TX_PILOT) || (state_q == TX_BIT) ||
                                (state_q == TX_STOPH);
endmodule

// file: wire_link_props.sv
// Assertions on the host-to-microphone link and on the microphone end's settings.
// Assumes one pclk domain; the bench instantiates it beside the first link.
module wire_link_props
  import wire_cfg_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link pins.
  input wire logic pdm_clk,
  input wire logic config_wire_pin,
  input wire logic wake,
  // Microphone end.
  input wire logic sound_above_threshold,
  input wire logic sound_below_cutoff,
  input wire logic analog_detect_enable,
  input wire logic [LOWPASS_W-1:0] analog_lowpass_code,
  input wire logic [THRESHOLD_W-1:0] analog_threshold_code,
  input wire logic config_unlocked,
  input wire logic link_clock_stopped,
  input wire logic write_accepted,
  input wire logic frame_dropped
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pdm_last_q;
  logic pin_last_q;
  logic seen_fall_q;
  logic [9:0] high_cnt_q;
  logic [9:0] low_cnt_q;
  logic link_rise;
  logic [7:0] settings;
  assign link_rise = pdm_clk & ~pdm_last_q;
  assign settings = {analog_detect_enable, analog_lowpass_code, analog_threshold_code};

  // Counts link clock rises in the current high and low stretch of the pin, saturating.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdm_last_q <= 1'b0;
      pin_last_q <= 1'b0;
      seen_fall_q <= 1'b0;
      high_cnt_q <= '0;
      low_cnt_q <= '0;
    end else begin
      pdm_last_q <= pdm_clk;
      pin_last_q <= config_wire_pin;
      seen_fall_q <= seen_fall_q | (pin_last_q & ~config_wire_pin);
      // A clock rise on the same edge as the pin rise belongs to the new symbol.
      if (config_wire_pin & ~pin_last_q) high_cnt_q <= {9'h000, link_rise};
      else if (config_wire_pin & link_rise & ~&high_cnt_q) high_cnt_q <= high_cnt_q + 10'h001;
      if (~config_wire_pin & pin_last_q) low_cnt_q <= '0;
      else if (~config_wire_pin & link_rise & ~&low_cnt_q) low_cnt_q <= low_cnt_q + 10'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_symbol_width: assert property ($fell(config_wire_pin) |->
    high_cnt_q >= 10'h008 && high_cnt_q <= 10'h081) else $error("high symbol width out of range");
  a_gap_min: assert property ($rose(config_wire_pin) && seen_fall_q |->
    low_cnt_q >= 10'h008) else $error("low gap shorter than the minimum pilot");
  a_pin_falls_low: assert property ($fell(config_wire_pin) |-> !pdm_clk)
    else $error("pin fell while the link clock was high");
  a_wake_exact: assert property (wake == ($past(analog_detect_enable) &&
    $past(link_clock_stopped) && $past(sound_above_threshold, 3) &&
    $past(sound_below_cutoff, 3))) else $error("wake does not follow its conditions");
  a_enable_commit: assert property ($changed(analog_detect_enable) |-> write_accepted)
    else $error("enable changed without an accepted write");
  a_codes_commit: assert property ($changed(settings[6:0]) |-> write_accepted)
    else $error("detect codes changed without an accepted write");
  a_locked_hold: assert property ($changed(settings) |-> config_unlocked)
    else $error("settings changed while locked");
  a_unlock_sticky: assert property (!$fell(config_unlocked))
    else $error("unlock state lost without reset");
  a_pulse_single: assert property (write_accepted |=> !write_accepted && !frame_dropped)
    else $error("accept pulse longer than one cycle");
  // The stop decode sees the clock through a synchroniser, three cycles late.
  a_idle_clock_low: assert property (link_clock_stopped |-> !$past(pdm_clk, 3))
    else $error("stopped link clock not low");

  c_accept: cover property (write_accepted);
  c_unlock: cover property ($rose(config_unlocked));
  c_wake: cover property ($rose(wake));
endmodule

// file: one_wire_activity_detect_config_tb_top.sv
// Bench: host end drives the microphone end; a spare microphone end is driven by the bench.
// Assumes the package constants and a 10 MHz pclk with active-low reset.
module one_wire_activity_detect_config_tb_top
  import wire_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BAD_P [8] = '{7, 21, 10, 10, 10, 10, 10, 10};
  localparam int BAD_Z [8] = '{7, 21, 16, 10, 10, 10, 10, 10};
  localparam int BAD_O [8] = '{21, 63, 30, 36, 19, 30, 30, 30};
  localparam logic [7:0] BAD_B [8] = '{8'hA6, 8'hA6, 8'hA6, 8'hA6, 8'hA6, 8'hA7, 8'hA4, 8'hA6};
  localparam int BAD_N [8] = '{24, 24, 24, 24, 24, 24, 24, 23};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic above = 1'b0;
  logic below = 1'b0;
  logic en1, unl1, acc1, drp1, stp1, en2, unl2, acc2, drp2;
  logic [LOWPASS_W-1:0] lp1, lp2;
  logic [THRESHOLD_W-1:0] th1, th2;
  int bad_count = 0;
  int check_count = 0;
  int n_acc1 = 0;
  int n_acc2 = 0;
  int n_drp2 = 0;
  int n_drp1 = 0;
  one_wire_if link();
  one_wire_if spare_link();

  wire_cfg_host wire_cfg_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  mic_config_rx mic_config_rx_i (.pclk(pclk), .presetn(presetn), .link(link),
    .sound_above_threshold(above), .sound_below_cutoff(below), .analog_detect_enable(en1),
    .analog_lowpass_code(lp1), .analog_threshold_code(th1), .config_unlocked(unl1),
    .link_clock_stopped(stp1), .write_accepted(acc1), .frame_dropped(drp1));
  mic_config_rx mic_config_rx_spare_i (.pclk(pclk), .presetn(presetn), .link(spare_link),
    .sound_above_threshold(1'b0), .sound_below_cutoff(1'b0), .analog_detect_enable(en2),
    .analog_lowpass_code(lp2), .analog_threshold_code(th2), .config_unlocked(unl2),
    .link_clock_stopped(), .write_accepted(acc2), .frame_dropped(drp2));
  wire_link_props wire_link_props_i (.pclk(pclk), .presetn(presetn), .pdm_clk(link.pdm_clk),
    .config_wire_pin(link.config_wire_pin), .wake(link.wake), .sound_above_threshold(above),
    .sound_below_cutoff(below), .analog_detect_enable(en1), .analog_lowpass_code(lp1),
    .analog_threshold_code(th1), .config_unlocked(unl1), .link_clock_stopped(stp1),
    .write_accepted(acc1), .frame_dropped(drp1));

  always #50 pclk = ~pclk;

  always @(posedge pclk) begin
    n_acc1 += int'(acc1);
    n_acc2 += int'(acc2);
    n_drp2 += int'(drp2);
    n_drp1 += int'(drp1);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Starts a write on the host end and polls until the host has sent it whole.
  task automatic host_frame(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, OFS_CMD, {16'h0000, a, d}, rd, e);
    rd = 32'h0000_0001;
    while (rd[STATUS_BUSY_BIT] !== 1'b0) apb(1'b0, OFS_STATUS, 32'h0000_0000, rd, e);
    repeat (8) @(posedge pclk);
  endtask

  // Holds the spare pin at v for n link cycles of four pclk; the pin moves only while low.
  task automatic seg(input logic v, input int n);
    spare_link.config_wire_pin <= v;
    repeat (n) begin
      @(posedge pclk);
      spare_link.pdm_clk <= 1'b1;
      repeat (2) @(posedge pclk);
      spare_link.pdm_clk <= 1'b0;
      repeat (1) @(posedge pclk);
    end
  endtask

  task automatic raw_frame(input int p, input int zw, input int ow, input logic [23:0] w,
                           input int nb, input logic stop_high);
    seg(1'b1, p);
    seg(1'b0, p);
    for (int i = 23; i > 23 - nb; i--) begin
      seg(1'b1, w[i] ? ow : zw);
      seg(1'b0, p);
    end
    if (stop_high) begin
      seg(1'b1, STOP_HIGH_CLKS + 1);
      seg(1'b0, p);
    end else begin
      seg(1'b0, STOP_LOW_TP * p);
    end
    repeat (8) @(posedge pclk);
  endtask

  task automatic good_frame(input logic [7:0] a, input logic [7:0] d);
    raw_frame(10, 10, 30, {DEV_WRITE_BYTE, a, d}, 24, 1'b0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #60_000_000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    logic [31:0] rd;
    logic e;
    spare_link.pdm_clk = 1'b0;
    spare_link.config_wire_pin = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'({en1, lp1, th1, unl1, link.wake, en2, lp2, th2, unl2}), 32'h0000_0000);
    apb(1'b0, OFS_CTRL, 32'h0000_0000, rd, e);
    check(rd, {16'h0000, DIV_RESET, 8'h00});
    apb(1'b1, 8'h10, 32'hFFFF_FFFF, rd, e);
    check(32'(e), 32'h0000_0001);
    apb(1'b0, 8'h10, 32'h0000_0000, rd, e);
    check(rd, 32'h0000_0000);
    $display("test reset and register map ends at %0t", $time);
    apb(1'b1, OFS_CTRL, 32'h0000_0103, rd, e);
    apb(1'b0, OFS_CTRL, 32'h0000_0000, rd, e);
    check(rd, {16'h0000, 8'(DIV_MIN), 8'h03});
    apb(1'b1, OFS_PILOT, 32'h0000_0003, rd, e);
    apb(1'b0, OFS_PILOT, 32'h0000_0000, rd, e);
    check(rd, 32'(PILOT_MIN));
    for (int i = 0; i < UNLOCK_STEPS; i++) begin
      check(32'(unl1), 32'h0000_0000);
      host_frame(UNLOCK_ADDR[i], UNLOCK_DATA);
    end
    check(32'(unl1), 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_1901, rd, e);
    host_frame(REG_LOWPASS, 8'h01);
    host_frame(REG_DETECT_ENABLE, 8'h08);
    check(32'({lp1, en1, 8'(n_acc1), 8'(n_drp1)}), 32'h0003_0700);
    above <= 1'b1;
    below <= 1'b1;
    repeat (20) @(posedge pclk);
    check(32'(link.wake), 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_1902, rd, e);
    for (int i = 0; i < 1000 && stp1 !== 1'b1; i++) @(posedge pclk);
    repeat (4) @(posedge pclk);
    check(32'(link.wake), 32'h0000_0001);
    below <= 1'b0;
    repeat (4) @(posedge pclk);
    check(32'(link.wake), 32'h0000_0000);
    $display("test host path and wake ends at %0t", $time);
    good_frame(REG_DETECT_ENABLE, 8'h08);
    good_frame(UNLOCK_ADDR[0], UNLOCK_DATA);
    good_frame(UNLOCK_ADDR[1], UNLOCK_DATA);
    good_frame(REG_LOWPASS, 8'h05);
    check(32'({en2, unl2, lp2, 8'(n_acc2)}), 32'h0000_0004);
    for (int i = 0; i < UNLOCK_STEPS; i++) good_frame(UNLOCK_ADDR[i], UNLOCK_DATA);
    check(32'(unl2), 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      int d0;
      d0 = n_drp2;
      raw_frame(BAD_P[i], BAD_Z[i], BAD_O[i], {BAD_B[i], REG_THRESHOLD, 8'h0F}, BAD_N[i], 1'b0);
      check(32'(n_drp2 > d0), 32'h0000_0001);
    end
    check(32'({th2, 8'(n_acc2)}), 32'h0000_0009);
    raw_frame(20, 30, 70, {DEV_WRITE_BYTE, REG_THRESHOLD, 8'h0F}, 24, 1'b1);
    check(32'(th2), 32'h0000_000F);
    raw_frame(8, 8, 16, {DEV_WRITE_BYTE, REG_DETECT_ENABLE, 8'h08}, 24, 1'b0);
    check(32'(en2), 32'h0000_0001);
    good_frame(REG_LOWPASS, 8'h07);
    good_frame(REG_DETECT_ENABLE, 8'h00);
    check(32'({en2, lp2}), 32'h0000_0007);
    $display("test spare end frames ends at %0t", $time);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'({unl1, en1, unl2, th2}), 32'h0000_0000);
    $display("test reset in mid-run ends at %0t", $time);
    report_and_stop();
  end
endmodule
